//--- include/radio_port_consts.svh
`ifndef RADIO_PORT_CONSTS_SVH
`define RADIO_PORT_CONSTS_SVH

// register offsets
`define OFS_EVENT_MASK 8'h91
`define OFS_EVENT_FLAGS 8'he9
`define OFS_BYTE_REG 8'hd9
`define OFS_STROBE 8'he1
`define OFS_MODEM_CFG3 8'hdb
`define OFS_MODEM_CFG4 8'hdc
`define OFS_PORT_STATUS 8'hdd

// event bit positions, shared by mask and flags
`define EV_TX_UNDERRUN 7
`define EV_RX_OVERRUN 6
`define EV_RX_TIMEOUT 5
`define EV_PACKET_DONE 4
`define EV_CARRIER_SENSE 3
`define EV_PREAMBLE_QUALITY 2
`define EV_CLEAR_CHANNEL 1
`define EV_FRAME_START 0

// modem_config_4 fields
`define CFG4_BW_EXP_HI 7
`define CFG4_BW_EXP_LO 6
`define CFG4_BW_MAN_HI 5
`define CFG4_BW_MAN_LO 4
`define CFG4_RATE_EXP_HI 3
`define CFG4_RATE_EXP_LO 0

// reset values and command codes
`define EVENT_MASK_RESET 8'h00
`define EVENT_FLAGS_RESET 8'h00
`define MODEM_CFG3_RESET 8'h00
`define MODEM_CFG4_RESET 8'h00
`define CMD_GO_IDLE 8'h04

// symbol rate and filter constants
`define RATE_BASE 9'h100
`define RATE_ACC_BITS 28
`define BW_BASE 3'h4
`define BW_SCALE_SHIFT 3

`endif

//--- include/radio_port_pkg.sv
`default_nettype none
package radio_port_pkg;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_RX_OVERRUN = 3'b010,
		ST_TX_UNDERRUN = 3'b100
	} link_state_t;

endpackage
`default_nettype wire

//--- verilog/radio_byte_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "radio_port_consts.svh"

module radio_byte_port #(
	parameter int RATE_EXP_MAX = 15
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic RX_BYTE_VALID,
	input wire logic [7:0] RX_BYTE,
	input wire logic TX_ACTIVE,
	input wire logic TX_BYTE_REQ,
	output logic TX_BYTE_VALID,
	output logic [7:0] TX_BYTE,
	input wire logic EVT_RX_TIMEOUT,
	input wire logic EVT_PACKET_DONE,
	input wire logic EVT_CARRIER_SENSE,
	input wire logic EVT_PREAMBLE_QUALITY,
	input wire logic EVT_CLEAR_CHANNEL,
	input wire logic EVT_FRAME_START,
	input wire logic DEEP_SLEEP,
	output logic GO_IDLE,
	output logic RADIO_IRQ_FLAG,
	output logic BYTE_IRQ_FLAG,
	output logic SYMBOL_TICK,
	output logic FILTER_TICK
);

	// refused at elaboration: the exponent field is four bits wide
	if (RATE_EXP_MAX < 0 || RATE_EXP_MAX > 15) begin : g_bad_rate_exp
		$error("RATE_EXP_MAX must lie in 0..15");
	end

	localparam logic [3:0] RATE_EXP_CAP = 4'(RATE_EXP_MAX);

	logic [7:0] radio_event_mask_r;
	logic [7:0] radio_event_flags_r;
	logic [7:0] radio_event_flags_nxt;
	logic [7:0] modem_config_3_r;
	logic [7:0] modem_config_4_r;
	logic [7:0] rx_data_r;
	logic rx_full_r;
	logic [7:0] tx_data_r;
	logic tx_full_r;
	logic [5:0] cond_prev_r;
	logic [28:0] rate_acc_r;
	logic [8:0] filter_cnt_r;
	radio_port_pkg::link_state_t state_r;

	wire wr_mask = WR && ADDR == `OFS_EVENT_MASK;
	wire wr_flags = WR && ADDR == `OFS_EVENT_FLAGS;
	wire wr_byte = WR && ADDR == `OFS_BYTE_REG;
	wire wr_cfg3 = WR && ADDR == `OFS_MODEM_CFG3;
	wire wr_cfg4 = WR && ADDR == `OFS_MODEM_CFG4;
	wire rd_byte = RD && ADDR == `OFS_BYTE_REG;
	wire idle_cmd = WR && ADDR == `OFS_STROBE && WDATA == `CMD_GO_IDLE;
	wire running = state_r == radio_port_pkg::ST_RUN;

	// a byte read in the same cycle as the next arrival is not an overrun
	wire overrun_now = running && RX_BYTE_VALID && rx_full_r && !rd_byte;
	wire underrun_now = running && TX_BYTE_REQ && !tx_full_r;
	wire tx_take = running && TX_BYTE_REQ && tx_full_r;

	wire [5:0] cond_now = {EVT_RX_TIMEOUT, EVT_PACKET_DONE, EVT_CARRIER_SENSE,
		EVT_PREAMBLE_QUALITY, EVT_CLEAR_CHANNEL, EVT_FRAME_START};
	wire [5:0] cond_rise = cond_now & ~cond_prev_r;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			radio_event_mask_r <= `EVENT_MASK_RESET;
		end else if (wr_mask) begin
			radio_event_mask_r <= WDATA;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			cond_prev_r <= 6'h00;
		end else begin
			cond_prev_r <= cond_now;
		end
	end

	// software clears by writing 0; a hardware set in the same cycle wins
	always_comb begin
		radio_event_flags_nxt = radio_event_flags_r;
		if (wr_flags) begin
			radio_event_flags_nxt = radio_event_flags_r & WDATA;
		end
		radio_event_flags_nxt[`EV_RX_TIMEOUT] = radio_event_flags_nxt[`EV_RX_TIMEOUT]
			| cond_rise[5];
		radio_event_flags_nxt[`EV_PACKET_DONE] = radio_event_flags_nxt[`EV_PACKET_DONE]
			| cond_rise[4] | overrun_now | underrun_now;
		radio_event_flags_nxt[`EV_CARRIER_SENSE] = radio_event_flags_nxt[`EV_CARRIER_SENSE]
			| cond_rise[3];
		radio_event_flags_nxt[`EV_PREAMBLE_QUALITY] =
			radio_event_flags_nxt[`EV_PREAMBLE_QUALITY] | cond_rise[2];
		radio_event_flags_nxt[`EV_CLEAR_CHANNEL] = radio_event_flags_nxt[`EV_CLEAR_CHANNEL]
			| cond_rise[1];
		radio_event_flags_nxt[`EV_FRAME_START] = radio_event_flags_nxt[`EV_FRAME_START]
			| cond_rise[0];
		radio_event_flags_nxt[`EV_RX_OVERRUN] = radio_event_flags_nxt[`EV_RX_OVERRUN]
			| overrun_now;
		radio_event_flags_nxt[`EV_TX_UNDERRUN] = radio_event_flags_nxt[`EV_TX_UNDERRUN]
			| underrun_now;
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			radio_event_flags_r <= `EVENT_FLAGS_RESET;
		end else begin
			radio_event_flags_r <= radio_event_flags_nxt;
		end
	end

	// combined flag follows the flags as they stand after this cycle's updates
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RADIO_IRQ_FLAG <= 1'b0;
		end else begin
			RADIO_IRQ_FLAG <= |(radio_event_flags_nxt & radio_event_mask_r);
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			state_r <= radio_port_pkg::ST_RUN;
		end else begin
			unique case (state_r)
				radio_port_pkg::ST_RUN: begin
					if (overrun_now) begin
						state_r <= radio_port_pkg::ST_RX_OVERRUN;
					end else if (underrun_now) begin
						state_r <= radio_port_pkg::ST_TX_UNDERRUN;
					end
				end
				radio_port_pkg::ST_RX_OVERRUN, radio_port_pkg::ST_TX_UNDERRUN: begin
					if (idle_cmd) begin
						state_r <= radio_port_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			GO_IDLE <= 1'b0;
		end else begin
			GO_IDLE <= idle_cmd;
		end
	end

	// receive half of the one-byte buffer
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rx_data_r <= 8'h00;
			rx_full_r <= 1'b0;
		end else if (DEEP_SLEEP) begin
			rx_full_r <= 1'b0;
		end else if (running && RX_BYTE_VALID) begin
			rx_data_r <= RX_BYTE;
			rx_full_r <= 1'b1;
		end else if (rd_byte) begin
			rx_full_r <= 1'b0;
		end
	end

	// transmit half; the data register is not cleared, only its valid bit
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			tx_data_r <= 8'h00;
			tx_full_r <= 1'b0;
		end else if (DEEP_SLEEP) begin
			tx_full_r <= 1'b0;
		end else if (wr_byte) begin
			tx_data_r <= WDATA;
			tx_full_r <= 1'b1;
		end else if (tx_take) begin
			tx_full_r <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			TX_BYTE_VALID <= 1'b0;
			TX_BYTE <= 8'h00;
		end else begin
			TX_BYTE_VALID <= tx_take;
			if (tx_take) begin
				TX_BYTE <= tx_data_r;
			end
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			BYTE_IRQ_FLAG <= 1'b0;
		end else begin
			BYTE_IRQ_FLAG <= running && (rx_full_r || (TX_ACTIVE && !tx_full_r));
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			modem_config_3_r <= `MODEM_CFG3_RESET;
		end else if (wr_cfg3) begin
			modem_config_3_r <= WDATA;
		end
	end

	// a rate exponent above RATE_EXP_MAX is clamped on write; the filter exponent is stored as written
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			modem_config_4_r <= `MODEM_CFG4_RESET;
		end else if (wr_cfg4) begin
			modem_config_4_r[`CFG4_BW_EXP_HI:`CFG4_BW_MAN_LO] <=
				WDATA[`CFG4_BW_EXP_HI:`CFG4_BW_MAN_LO];
			if (WDATA[`CFG4_RATE_EXP_HI:`CFG4_RATE_EXP_LO] > RATE_EXP_CAP) begin
				modem_config_4_r[`CFG4_RATE_EXP_HI:`CFG4_RATE_EXP_LO] <= RATE_EXP_CAP;
			end else begin
				modem_config_4_r[`CFG4_RATE_EXP_HI:`CFG4_RATE_EXP_LO] <=
					WDATA[`CFG4_RATE_EXP_HI:`CFG4_RATE_EXP_LO];
			end
		end
	end

	wire [7:0] rate_mantissa = modem_config_3_r;
	wire [3:0] rate_exponent = modem_config_4_r[`CFG4_RATE_EXP_HI:`CFG4_RATE_EXP_LO];
	wire [1:0] filter_bw_mantissa = modem_config_4_r[`CFG4_BW_MAN_HI:`CFG4_BW_MAN_LO];
	wire [1:0] filter_bw_exponent = modem_config_4_r[`CFG4_BW_EXP_HI:`CFG4_BW_EXP_LO];

	// phase accumulator: carry out of bit 27 into bit 28 is one symbol, MCLK is the reference
	wire [28:0] rate_step = 29'({1'b0, rate_mantissa} + `RATE_BASE) << rate_exponent;
	wire [28:0] rate_sum = {1'b0, rate_acc_r[`RATE_ACC_BITS-1:0]} + rate_step;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rate_acc_r <= 29'h0000000;
			SYMBOL_TICK <= 1'b0;
		end else begin
			rate_acc_r <= rate_sum;
			SYMBOL_TICK <= rate_sum[`RATE_ACC_BITS];
		end
	end

	// decimation period 8*(4+m)*2^e clocks drives the digital channel filter
	wire [8:0] filter_div = 9'({`BW_BASE + {1'b0, filter_bw_mantissa}, 3'h0})
		<< filter_bw_exponent;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			filter_cnt_r <= 9'h000;
			FILTER_TICK <= 1'b0;
		end else if (filter_cnt_r >= filter_div - 9'h001) begin
			filter_cnt_r <= 9'h000;
			FILTER_TICK <= 1'b1;
		end else begin
			filter_cnt_r <= filter_cnt_r + 9'h001;
			FILTER_TICK <= 1'b0;
		end
	end

	wire [7:0] port_status = {5'h00, state_r};

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				`OFS_EVENT_MASK: RDATA <= radio_event_mask_r;
				`OFS_EVENT_FLAGS: RDATA <= radio_event_flags_r;
				`OFS_BYTE_REG: RDATA <= rx_data_r;
				`OFS_MODEM_CFG3: RDATA <= modem_config_3_r;
				`OFS_MODEM_CFG4: RDATA <= modem_config_4_r;
				`OFS_PORT_STATUS: RDATA <= port_status;
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	property p_mask_write;
		@(posedge MCLK) disable iff (RESET)
		wr_mask |=> radio_event_mask_r == $past(WDATA);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_timeout_gate;
		@(posedge MCLK) disable iff (RESET)
		(radio_event_flags_nxt == 8'h20 && radio_event_mask_r == 8'h20 && !wr_mask)
			|=> RADIO_IRQ_FLAG;
	endproperty
	a_timeout_gate: assert property (p_timeout_gate) else $error("timeout not raised");

	property p_no_irq_masked;
		@(posedge MCLK) disable iff (RESET)
		(radio_event_mask_r == 8'h00) |=> !RADIO_IRQ_FLAG;
	endproperty
	a_no_irq_masked: assert property (p_no_irq_masked) else $error("masked irq seen");

	property p_overrun;
		@(posedge MCLK) disable iff (RESET)
		overrun_now |=> state_r == radio_port_pkg::ST_RX_OVERRUN
			&& radio_event_flags_r[`EV_RX_OVERRUN] && radio_event_flags_r[`EV_PACKET_DONE];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not entered");

	property p_underrun;
		@(posedge MCLK) disable iff (RESET)
		(underrun_now && !overrun_now) |=> state_r == radio_port_pkg::ST_TX_UNDERRUN
			&& radio_event_flags_r[`EV_TX_UNDERRUN] && radio_event_flags_r[`EV_PACKET_DONE];
	endproperty
	a_underrun: assert property (p_underrun) else $error("underrun not entered");

	property p_error_holds;
		@(posedge MCLK) disable iff (RESET)
		(!running && !idle_cmd) |=> !running;
	endproperty
	a_error_holds: assert property (p_error_holds) else $error("error left early");

	property p_idle_exit;
		@(posedge MCLK) disable iff (RESET)
		idle_cmd |=> running && GO_IDLE;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle strobe ignored");

	property p_edge_set;
		@(posedge MCLK) disable iff (RESET)
		(!EVT_FRAME_START ##1 EVT_FRAME_START) |=> radio_event_flags_r[`EV_FRAME_START];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge flag missed");

	property p_byte_loop;
		@(posedge MCLK) disable iff (RESET)
		(RX_BYTE_VALID && running && !DEEP_SLEEP) ##1 (RD && ADDR == `OFS_BYTE_REG)
			|=> RDATA == $past(RX_BYTE, 2);
	endproperty
	a_byte_loop: assert property (p_byte_loop) else $error("byte readback wrong");

	property p_byte_flag;
		@(posedge MCLK) disable iff (RESET)
		(running && rx_full_r) |=> BYTE_IRQ_FLAG;
	endproperty
	a_byte_flag: assert property (p_byte_flag) else $error("byte flag missing");

	property p_rate_cap;
		@(posedge MCLK) disable iff (RESET)
		1'b1 |-> rate_exponent <= RATE_EXP_CAP;
	endproperty
	a_rate_cap: assert property (p_rate_cap) else $error("rate exponent too large");

	property p_filter_period;
		@(posedge MCLK) disable iff (RESET)
		FILTER_TICK |-> filter_cnt_r == 9'h000;
	endproperty
	a_filter_period: assert property (p_filter_period) else $error("filter tick off");

endmodule
`default_nettype wire

//--- tb/radio_modem_model.sv
`timescale 1ns/1ns
`default_nettype none
module radio_modem_model (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic rx_req,
	input wire logic [7:0] rx_data,
	input wire logic tx_req,
	input wire logic TX_BYTE_VALID,
	input wire logic [7:0] TX_BYTE,
	output logic RX_BYTE_VALID,
	output logic [7:0] RX_BYTE,
	output logic TX_ACTIVE,
	output logic TX_BYTE_REQ,
	output logic tx_seen,
	output logic [7:0] tx_got
);
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RX_BYTE_VALID <= 1'b0;
			RX_BYTE <= 8'h00;
			TX_ACTIVE <= 1'b0;
			TX_BYTE_REQ <= 1'b0;
			tx_seen <= 1'b0;
			tx_got <= 8'h00;
		end else begin
			RX_BYTE_VALID <= rx_req;
			// between deliveries the last byte and its inverse alternate every cycle
			RX_BYTE <= rx_req ? rx_data : ~RX_BYTE;
			TX_BYTE_REQ <= tx_req;
			TX_ACTIVE <= tx_req | TX_BYTE_REQ;
			tx_seen <= TX_BYTE_VALID;
			if (TX_BYTE_VALID) begin
				tx_got <= TX_BYTE;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/radio_byte_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module radio_byte_port_bench;
	logic MCLK, RESET, WR, RD, DEEP_SLEEP, rx_req, tx_req, tx_seen;
	logic [7:0] ADDR, WDATA, RDATA, rx_data, TX_BYTE, RX_BYTE, tx_got;
	logic RX_BYTE_VALID, TX_ACTIVE, TX_BYTE_REQ, TX_BYTE_VALID, GO_IDLE;
	logic RADIO_IRQ_FLAG, BYTE_IRQ_FLAG, SYMBOL_TICK, FILTER_TICK;
	logic [5:0] evt;
	int n_fail, n_checks;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e; logic wen;} row_t;
	row_t rows[9];

	radio_byte_port #(.RATE_EXP_MAX(14)) dut (.MCLK, .RESET, .ADDR, .WDATA, .WR, .RD,
		.RDATA, .RX_BYTE_VALID, .RX_BYTE, .TX_ACTIVE, .TX_BYTE_REQ, .TX_BYTE_VALID,
		.TX_BYTE, .EVT_RX_TIMEOUT(evt[5]), .EVT_PACKET_DONE(evt[4]),
		.EVT_CARRIER_SENSE(evt[3]), .EVT_PREAMBLE_QUALITY(evt[2]),
		.EVT_CLEAR_CHANNEL(evt[1]), .EVT_FRAME_START(evt[0]), .DEEP_SLEEP, .GO_IDLE,
		.RADIO_IRQ_FLAG, .BYTE_IRQ_FLAG, .SYMBOL_TICK, .FILTER_TICK);
	radio_modem_model modem (.MCLK, .RESET, .rx_req, .rx_data, .tx_req, .TX_BYTE_VALID,
		.TX_BYTE, .RX_BYTE_VALID, .RX_BYTE, .TX_ACTIVE, .TX_BYTE_REQ, .tx_seen, .tx_got);

	initial begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end

	task print_verdict;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, e, "read");
	endtask

	task pulse_rx(input logic [7:0] d);
		@(posedge MCLK);
		rx_req <= 1'b1;
		rx_data <= d;
		@(posedge MCLK);
		rx_req <= 1'b0;
	endtask

	task pulse_tx;
		@(posedge MCLK);
		tx_req <= 1'b1;
		@(posedge MCLK);
		tx_req <= 1'b0;
	endtask

	// sel 0 waits on the byte flag, 1 on a byte taken by the modem
	task wait_hi(input logic sel);
		int k;
		k = 0;
		while ((sel ? tx_seen : BYTE_IRQ_FLAG) !== 1'b1) begin
			if (k++ == 40) begin
				n_fail++;
				$display("CHECK FAILED t=%0t wait timed out", $time);
				print_verdict;
			end
			@(posedge MCLK);
			#1;
		end
	endtask

	// window is a whole number of filter periods, so the filter count is exact
	task ticks(input logic [7:0] cfg4, input logic [7:0] nf);
		int f, s;
		f = 0;
		s = 0;
		wr(8'hdc, cfg4);
		cyc(2);
		repeat (2240) begin
			@(posedge MCLK);
			#1;
			if (FILTER_TICK === 1'b1) f++;
			if (SYMBOL_TICK === 1'b1) s++;
		end
		chk(8'(f), nf, "filter ticks");
		n_checks++;
		if (s < 69 || s > 70) begin
			n_fail++;
			$display("CHECK FAILED t=%0t symbol ticks %0d", $time, s);
		end
	endtask

	initial begin
		RESET = 1'b1;
		{WR, RD, DEEP_SLEEP, rx_req, tx_req} = 5'h00;
		{ADDR, WDATA, rx_data} = 24'h000000;
		evt = 6'h00;
		rows = '{'{8'h91, 8'h00, 8'h00, 1'b0}, '{8'he9, 8'h00, 8'h00, 1'b0},
			'{8'hdb, 8'h00, 8'h00, 1'b0}, '{8'hdc, 8'h00, 8'h00, 1'b0},
			'{8'hdd, 8'h00, 8'h01, 1'b0}, '{8'h91, 8'hff, 8'hff, 1'b1},
			'{8'hdd, 8'hff, 8'h01, 1'b1}, '{8'h00, 8'hff, 8'h00, 1'b1},
			'{8'hdc, 8'h5d, 8'h5d, 1'b1}};
		repeat (16) @(posedge MCLK);
		RESET <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wen) wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		for (int i = 0; i < 8; i++) begin
			wr(8'h91, 8'h01 << i);
			rd(8'h91, 8'h01 << i);
		end
		wr(8'h91, 8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge MCLK);
			evt <= 6'h01 << i;
			cyc(3);
			rd(8'he9, 8'h01 << i);
			chk({7'h0, RADIO_IRQ_FLAG}, 8'h00, "masked irq");
			wr(8'h91, 8'h01 << i);
			cyc(2);
			#1;
			chk({7'h0, RADIO_IRQ_FLAG}, 8'h01, "enabled irq");
			wr(8'he9, 8'h00);
			cyc(2);
			rd(8'he9, 8'h00);
			chk({7'h0, RADIO_IRQ_FLAG}, 8'h00, "irq after clear");
			@(posedge MCLK);
			evt <= 6'h00;
			wr(8'h91, 8'h00);
		end
		pulse_rx(8'ha5);
		wait_hi(1'b0);
		rd(8'hd9, 8'ha5);
		cyc(2);
		#1;
		chk({7'h0, BYTE_IRQ_FLAG}, 8'h00, "byte flag after read");
		wr(8'h91, 8'h40);
		pulse_rx(8'h11);
		pulse_rx(8'h22);
		cyc(3);
		rd(8'he9, 8'h50);
		chk({7'h0, RADIO_IRQ_FLAG}, 8'h01, "overrun irq");
		rd(8'hdd, 8'h02);
		wr(8'he1, 8'h03);
		#1;
		chk({7'h0, GO_IDLE}, 8'h00, "other strobe");
		rd(8'hdd, 8'h02);
		wr(8'he1, 8'h04);
		#1;
		chk({7'h0, GO_IDLE}, 8'h01, "idle strobe");
		rd(8'hdd, 8'h01);
		// the byte kept through overrun must go, or the next arrival overruns again
		rd(8'hd9, 8'h22);
		pulse_rx(8'hc3);
		rd(8'hd9, 8'hc3);
		wr(8'he9, 8'h00);
		wr(8'hd9, 8'h3c);
		pulse_tx;
		wait_hi(1'b1);
		chk(tx_got, 8'h3c, "tx byte");
		wr(8'h91, 8'h80);
		wr(8'hd9, 8'h77);
		pulse_rx(8'h5a);
		wait_hi(1'b0);
		@(posedge MCLK);
		DEEP_SLEEP <= 1'b1;
		cyc(2);
		DEEP_SLEEP <= 1'b0;
		cyc(2);
		#1;
		chk({7'h0, BYTE_IRQ_FLAG}, 8'h00, "sleep empties rx");
		pulse_tx;
		cyc(3);
		rd(8'he9, 8'h90);
		chk({7'h0, RADIO_IRQ_FLAG}, 8'h01, "underrun irq");
		rd(8'hdd, 8'h04);
		wr(8'he1, 8'h04);
		rd(8'hdd, 8'h01);
		wr(8'hdb, 8'hff);
		ticks(8'h0f, 8'd70);
		ticks(8'h7e, 8'd20);
		print_verdict;
	end
endmodule
`default_nettype wire
